// ==== pcp_config_regs.sv ====
`timescale 1ns/100ps
module pcp_config_regs #(
	parameter int STEP_FINE_CYC = pcp_pkg::STEP_FINE_CYC
) (
	input  wire logic       ref_clk,
	input  wire logic       rstn,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output wire logic       sda_o,
	output wire logic       sda_oe,
	input  wire logic       clk_pin_i,
	output wire logic       clk_pin_o,
	output wire logic       clk_pin_oe,
	input  wire logic       aux_output_two_level,
	input  wire logic       aux_output_two_open_drain,
	input  wire logic       seq_up_start,
	input  wire logic [3:0] seq_up_code,
	input  wire logic       seq_down_start,
	input  wire logic [3:0] seq_down_code,
	output wire logic       seq_up_done,
	output wire logic       seq_down_done,
	output wire logic       clock_pin_pulldown_on,
	output wire logic       trigger_pin_pulldown_on,
	output wire logic       thermal_alert_threshold_sel,
	output wire logic       dither_switching_on,
	output wire logic       pll_enable,
	output wire logic       use_ext_ref,
	output wire logic       ref_change_event,
	output wire logic [4:0] ref_clock_rate_code,
	input  wire logic [3:0] rail_uv_ok,
	input  wire logic [3:0] rail_ov_ok,
	input  wire logic       thermal_warning,
	input  wire logic [3:0] pg_fault_flags,
	output wire logic       power_ok_out_o,
	output wire logic       power_ok_out_oe,
	output wire logic       power_ok_valid,
	output wire logic       power_ok_continuous_mode
);

	typedef struct packed {
		logic [7:0]       cfg;
		logic [7:0]       pll;
		logic [7:0]       pok_a;
		logic [7:0]       pok_b;
		logic [1:0]       busy;
		logic [1:0]       done;
		logic [1:0][4:0]  ticks;
		logic [1:0][15:0] sub;
		logic             ref_q;
		logic             ref_present;
		logic [7:0]       loss_cnt;
		logic             ref_evt;
		logic             use_ref;
		logic             pin_o;
		logic             pin_oe;
		logic             pok_valid;
		logic             pok_o;
		logic             pok_oe;
	} pcp_regs_t;

	pcp_regs_t  r_ff;
	pcp_regs_t  nxt_r;
	logic [1:0] rst_sync_ff;
	logic       rst_n;
	logic [7:0] rd_addr;
	logic [7:0] rd_data;
	logic       wr_stb;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;

	////////////////////////////////////////////////////////////////////////
	// Delay step count in half-millisecond units: coarse range doubles it
	function automatic logic [4:0] delay_ticks(input logic [3:0] code,
		input logic coarse);
		delay_ticks = coarse ? {code, 1'b0} : {1'b0, code};
	endfunction : delay_ticks

	// Register read decode; unmapped offsets read as zero
	function automatic logic [7:0] read_reg(input logic [7:0] addr,
		input pcp_regs_t r);
		unique case (addr)
			pcp_pkg::ADDR_MISC_CONFIG: read_reg = r.cfg;
			pcp_pkg::ADDR_CLOCK_PLL:   read_reg = r.pll;
			pcp_pkg::ADDR_POWER_OK_A:  read_reg = r.pok_a;
			pcp_pkg::ADDR_POWER_OK_B:  read_reg = r.pok_b;
			default:                   read_reg = pcp_pkg::READ_UNMAPPED;
		endcase
	endfunction : read_reg

	////////////////////////////////////////////////////////////////////////
	// Reset release through two stages so the struct leaves reset cleanly
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rst_sync_ff <= 2'b00;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end

	assign rst_n = rst_sync_ff[1];

	////////////////////////////////////////////////////////////////////////
	// Serial register access
	pcp_serial_slave u_slave (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.scl_i   (scl_i),
		.sda_i   (sda_i),
		.sda_o   (sda_o),
		.sda_oe  (sda_oe),
		.rd_addr (rd_addr),
		.rd_data (rd_data),
		.wr_stb  (wr_stb),
		.wr_addr (wr_addr),
		.wr_data (wr_data)
	);

	assign rd_data = read_reg(rd_addr, r_ff);

	////////////////////////////////////////////////////////////////////////
	// Next-state logic for the whole block
	always_comb begin
		logic [1:0] start;
		logic [1:0] coarse;
		logic [1:0][3:0] code;
		logic       clk_role;
		logic       edge_seen;
		logic       rate_ok;
		logic [3:0] rail_ok;
		logic [3:0] src_en;
		logic       live_ok;
		logic       fault_ok;
		logic       valid;
		logic       level;
		start     = {seq_down_start, seq_up_start};
		coarse    = {r_ff.cfg[pcp_pkg::CFG_SHUTDOWN_RANGE],
			r_ff.cfg[pcp_pkg::CFG_STARTUP_RANGE]};
		code      = {seq_down_code, seq_up_code};
		clk_role  = r_ff.cfg[pcp_pkg::CFG_CLK_PIN_FUNC];
		edge_seen = 1'b0;
		rate_ok   = 1'b0;
		rail_ok   = 4'h0;
		src_en    = 4'h0;
		live_ok   = 1'b0;
		fault_ok  = 1'b0;
		valid     = 1'b0;
		level     = 1'b0;
		nxt_r     = r_ff;

		// Register writes; reserved bits are stored as written
		if (wr_stb) begin
			unique case (wr_addr)
				pcp_pkg::ADDR_MISC_CONFIG: nxt_r.cfg   = wr_data;
				pcp_pkg::ADDR_CLOCK_PLL:   nxt_r.pll   = wr_data;
				pcp_pkg::ADDR_POWER_OK_A:  nxt_r.pok_a = wr_data;
				pcp_pkg::ADDR_POWER_OK_B:  nxt_r.pok_b = wr_data;
				default:                   nxt_r.cfg   = r_ff.cfg;
			endcase
		end

		// Sequencing delays; the range is sampled at the start request
		for (int i = 0; i < 2; i++) begin
			nxt_r.done[i] = 1'b0;
			if (start[i]) begin
				nxt_r.ticks[i] = delay_ticks(code[i], coarse[i]);
				nxt_r.sub[i]   = 16'h0000;
				nxt_r.busy[i]  = 1'b1;
			end else if (r_ff.busy[i]) begin
				if (r_ff.ticks[i] == 5'h00) begin
					// Zero code finishes here; done is high two cycles after the request
					nxt_r.busy[i] = 1'b0;
					nxt_r.done[i] = 1'b1;
				end else if (r_ff.sub[i] == 16'(STEP_FINE_CYC - 1)) begin
					nxt_r.sub[i]   = 16'h0000;
					nxt_r.ticks[i] = r_ff.ticks[i] - 5'h01;
				end else begin
					nxt_r.sub[i] = r_ff.sub[i] + 16'h0001;
				end
			end
		end

		// Clock pin role: input only in clock role, else drives output two
		if (clk_role) begin
			nxt_r.pin_o  = 1'b0;
			nxt_r.pin_oe = 1'b0;
		end else if (aux_output_two_open_drain) begin
			nxt_r.pin_o  = 1'b0;
			nxt_r.pin_oe = ~aux_output_two_level;
		end else begin
			nxt_r.pin_o  = aux_output_two_level;
			nxt_r.pin_oe = 1'b1;
		end

		// Reference presence: an edge within the loss window keeps it alive.
		// Bit five of clock control steers nothing here.
		nxt_r.ref_q = clk_pin_i;
		edge_seen   = clk_pin_i ^ r_ff.ref_q;
		if (!r_ff.pll[pcp_pkg::PLL_ENABLE_BIT] || !clk_role) begin
			nxt_r.ref_present = 1'b0;
			nxt_r.loss_cnt    = 8'h00;
		end else if (edge_seen) begin
			nxt_r.ref_present = 1'b1;
			nxt_r.loss_cnt    = 8'h00;
		end else if (r_ff.loss_cnt == 8'(pcp_pkg::REF_LOSS_CYC - 1)) begin
			nxt_r.ref_present = 1'b0;
		end else begin
			nxt_r.loss_cnt = r_ff.loss_cnt + 8'h01;
		end

		// Event on each change of presence while the PLL is enabled
		nxt_r.ref_evt = r_ff.pll[pcp_pkg::PLL_ENABLE_BIT]
			& (nxt_r.ref_present ^ r_ff.ref_present);

		// Reserved rate codes keep the internal oscillator; next-state
		// settings drop the reference on the same edge as a disable
		rate_ok = nxt_r.pll[pcp_pkg::PLL_RATE_MSB:0]
			<= pcp_pkg::RATE_CODE_MAX;
		nxt_r.use_ref = nxt_r.pll[pcp_pkg::PLL_ENABLE_BIT]
			& nxt_r.cfg[pcp_pkg::CFG_CLK_PIN_FUNC]
			& r_ff.ref_present & rate_ok;

		// Per-rail check; window bits add the overvoltage test
		for (int k = 0; k < 4; k++) begin
			if (k >= pcp_pkg::RAIL_LIN0) begin
				rail_ok[k] = rail_uv_ok[k] & (rail_ov_ok[k]
					| ~r_ff.pok_a[pcp_pkg::POK_LIN_WINDOW_BIT]);
			end else begin
				rail_ok[k] = rail_uv_ok[k] & (rail_ov_ok[k]
					| ~r_ff.pok_a[pcp_pkg::POK_SW_WINDOW_BIT]);
			end
		end

		// Only selected rails count; an empty selection passes
		src_en   = r_ff.pok_a[pcp_pkg::POK_SRC_MSB:0];
		live_ok  = &(rail_ok | ~src_en);
		fault_ok = ~|(pg_fault_flags & src_en);
		valid    = r_ff.pok_b[pcp_pkg::POK_FAULT_SRC_BIT] ? fault_ok
			: live_ok;
		if (r_ff.pok_b[pcp_pkg::POK_THERMAL_BIT] && thermal_warning) begin
			valid = 1'b0;
		end
		nxt_r.pok_valid = valid;

		// Output pin: polarity first, then push-pull or open-drain drive
		level = valid ^ r_ff.pok_a[pcp_pkg::POK_POLARITY_BIT];
		if (r_ff.pok_a[pcp_pkg::POK_DRAIN_BIT]) begin
			nxt_r.pok_o  = 1'b0;
			nxt_r.pok_oe = ~level;
		end else begin
			nxt_r.pok_o  = level;
			nxt_r.pok_oe = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			r_ff <= '{cfg:   pcp_pkg::RST_MISC_CONFIG,
				pll:   pcp_pkg::RST_CLOCK_PLL,
				pok_a: pcp_pkg::RST_POWER_OK_A,
				pok_b: pcp_pkg::RST_POWER_OK_B,
				default: '0};
		end else begin
			r_ff <= nxt_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs, all taken from the state register
	assign seq_up_done   = r_ff.done[0];
	assign seq_down_done = r_ff.done[1];
	assign clk_pin_o     = r_ff.pin_o;
	assign clk_pin_oe    = r_ff.pin_oe;

	// Pull-down bit holds in either pin role
	assign clock_pin_pulldown_on = r_ff.cfg[pcp_pkg::CFG_CLK_PIN_PD];
	assign trigger_pin_pulldown_on =
		r_ff.cfg[pcp_pkg::CFG_TRIG_PIN_PD];
	assign thermal_alert_threshold_sel =
		r_ff.cfg[pcp_pkg::CFG_THERMAL_SEL];
	assign dither_switching_on = r_ff.cfg[pcp_pkg::CFG_DITHER];

	assign pll_enable          = r_ff.pll[pcp_pkg::PLL_ENABLE_BIT];
	assign use_ext_ref         = r_ff.use_ref;
	assign ref_change_event    = r_ff.ref_evt;
	assign ref_clock_rate_code = r_ff.pll[pcp_pkg::PLL_RATE_MSB:0];

	assign power_ok_out_o   = r_ff.pok_o;
	assign power_ok_out_oe  = r_ff.pok_oe;
	assign power_ok_valid   = r_ff.pok_valid;
	assign power_ok_continuous_mode = r_ff.pok_b[pcp_pkg::POK_MODE_BIT];

endmodule : pcp_config_regs

// ==== pcp_pkg.sv ====
package pcp_pkg;

	// Register offsets on the serial link
	localparam logic [7:0] ADDR_MISC_CONFIG  = 8'h13;
	localparam logic [7:0] ADDR_CLOCK_PLL    = 8'h14;
	localparam logic [7:0] ADDR_POWER_OK_A   = 8'h15;
	localparam logic [7:0] ADDR_POWER_OK_B   = 8'h16;

	// Reset values, and the value read at unmapped offsets
	localparam logic [7:0] RST_MISC_CONFIG   = 8'h06;
	localparam logic [7:0] RST_CLOCK_PLL     = 8'h01;
	localparam logic [7:0] RST_POWER_OK_A    = 8'h73;
	localparam logic [7:0] RST_POWER_OK_B    = 8'h04;
	localparam logic [7:0] READ_UNMAPPED     = 8'h00;

	// Misc configuration fields
	localparam int CFG_STARTUP_RANGE  = 6;
	localparam int CFG_SHUTDOWN_RANGE = 5;
	localparam int CFG_CLK_PIN_FUNC   = 4;
	localparam int CFG_CLK_PIN_PD     = 3;
	localparam int CFG_TRIG_PIN_PD    = 2;
	localparam int CFG_THERMAL_SEL    = 1;
	localparam int CFG_DITHER         = 0;

	// Clock and PLL control fields
	localparam int PLL_ENABLE_BIT     = 6;
	localparam int PLL_RESERVED_BIT   = 5;
	localparam int PLL_RATE_MSB       = 4;
	localparam logic [4:0] RATE_CODE_MAX = 5'h17;

	// Power-ok control A fields; low nibble is the rail source mask
	localparam int POK_POLARITY_BIT   = 7;
	localparam int POK_DRAIN_BIT      = 6;
	localparam int POK_LIN_WINDOW_BIT = 5;
	localparam int POK_SW_WINDOW_BIT  = 4;
	localparam int POK_SRC_MSB        = 3;

	// Power-ok control B fields
	localparam int POK_THERMAL_BIT    = 2;
	localparam int POK_FAULT_SRC_BIT  = 1;
	localparam int POK_MODE_BIT       = 0;

	// Rail order in every four-bit rail vector
	localparam int RAIL_SW0  = 0;
	localparam int RAIL_SW1  = 1;
	localparam int RAIL_LIN0 = 2;
	localparam int RAIL_LIN1 = 3;

	// Timing
	localparam int CLK_PERIOD_NS   = 10;
	localparam int STEP_FINE_US    = 500;
	localparam int STEP_FINE_CYC   = STEP_FINE_US * 1000 / CLK_PERIOD_NS;
	localparam int REF_LOSS_NS     = 2000;
	localparam int REF_LOSS_CYC    = REF_LOSS_NS / CLK_PERIOD_NS;

	// Serial slave
	localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h60; // Arbitrary value
	localparam logic [3:0] BITS_PER_BYTE    = 4'h8;

	typedef enum logic [2:0] {
		SL_IDLE     = 3'b000,
		SL_ADDR     = 3'b001,
		SL_ACK_ADDR = 3'b010,
		SL_WR_BYTE  = 3'b011,
		SL_ACK_WR   = 3'b100,
		SL_RD_BYTE  = 3'b101,
		SL_ACK_RD   = 3'b110
	} pcp_slave_state_t;

endpackage : pcp_pkg

// ==== pcp_serial_slave.sv ====
`timescale 1ns/100ps
module pcp_serial_slave #(
	parameter logic [6:0] DEV_ADDR = pcp_pkg::DEV_ADDR_DEFAULT
) (
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output wire logic       sda_o,
	output wire logic       sda_oe,
	output wire logic [7:0] rd_addr,
	input  wire logic [7:0] rd_data,
	output wire logic       wr_stb,
	output wire logic [7:0] wr_addr,
	output wire logic [7:0] wr_data
);

	typedef struct packed {
		logic                      scl_q;
		logic                      sda_q;
		pcp_pkg::pcp_slave_state_t st;
		logic [3:0]                cnt;
		logic [7:0]                shift;
		logic [7:0]                ptr;
		logic                      rw;
		logic                      first;
		logic                      oe;
		logic                      wr;
		logic [7:0]                waddr;
		logic [7:0]                wdata;
	} pcp_slave_t;

	pcp_slave_t r_ff;
	pcp_slave_t nxt_r;
	logic       rise;
	logic       fall;
	logic       start_cond;
	logic       stop_cond;

	////////////////////////////////////////////////////////////////////////
	// Line events; pins arrive synchronous so one delay stage suffices
	assign rise       = ~r_ff.scl_q & scl_i;
	assign fall       = r_ff.scl_q & ~scl_i;
	assign start_cond = r_ff.scl_q & scl_i & r_ff.sda_q & ~sda_i;
	assign stop_cond  = r_ff.scl_q & scl_i & ~r_ff.sda_q & sda_i;

	////////////////////////////////////////////////////////////////////////
	// Byte engine: pointer byte first, then data with auto-increment
	always_comb begin
		nxt_r       = r_ff;
		nxt_r.scl_q = scl_i;
		nxt_r.sda_q = sda_i;
		nxt_r.wr    = 1'b0;
		if (start_cond) begin
			nxt_r.st    = pcp_pkg::SL_ADDR;
			nxt_r.cnt   = 4'h0;
			nxt_r.first = 1'b1;
			nxt_r.oe    = 1'b0;
		end else if (stop_cond) begin
			nxt_r.st = pcp_pkg::SL_IDLE;
			nxt_r.oe = 1'b0;
		end else begin
			unique case (r_ff.st)
				pcp_pkg::SL_IDLE: begin
					nxt_r.oe = 1'b0;
				end
				pcp_pkg::SL_ADDR, pcp_pkg::SL_WR_BYTE: begin
					if (rise) begin
						nxt_r.shift = {r_ff.shift[6:0], sda_i};
						nxt_r.cnt   = r_ff.cnt + 4'h1;
					end else if (fall && r_ff.cnt == pcp_pkg::BITS_PER_BYTE) begin
						nxt_r.cnt = 4'h0;
						if (r_ff.st == pcp_pkg::SL_ADDR) begin
							if (r_ff.shift[7:1] == DEV_ADDR) begin
								nxt_r.st = pcp_pkg::SL_ACK_ADDR;
								nxt_r.rw = r_ff.shift[0];
								nxt_r.oe = 1'b1;
							end else begin
								nxt_r.st = pcp_pkg::SL_IDLE;
							end
						end else begin
							nxt_r.st = pcp_pkg::SL_ACK_WR;
							nxt_r.oe = 1'b1;
							if (r_ff.first) begin
								nxt_r.ptr   = r_ff.shift;
								nxt_r.first = 1'b0;
							end else begin
								nxt_r.wr    = 1'b1;
								nxt_r.waddr = r_ff.ptr;
								nxt_r.wdata = r_ff.shift;
								nxt_r.ptr   = r_ff.ptr + 8'h01;
							end
						end
					end
				end
				pcp_pkg::SL_ACK_ADDR: begin
					if (fall) begin
						if (r_ff.rw) begin
							nxt_r.st    = pcp_pkg::SL_RD_BYTE;
							nxt_r.shift = rd_data;
							nxt_r.oe    = ~rd_data[7];
						end else begin
							nxt_r.st = pcp_pkg::SL_WR_BYTE;
							nxt_r.oe = 1'b0;
						end
					end
				end
				pcp_pkg::SL_ACK_WR: begin
					if (fall) begin
						nxt_r.st = pcp_pkg::SL_WR_BYTE;
						nxt_r.oe = 1'b0;
					end
				end
				pcp_pkg::SL_RD_BYTE: begin
					if (fall) begin
						if (r_ff.cnt == pcp_pkg::BITS_PER_BYTE - 4'h1) begin
							nxt_r.st  = pcp_pkg::SL_ACK_RD;
							nxt_r.oe  = 1'b0;
							nxt_r.ptr = r_ff.ptr + 8'h01;
						end else begin
							nxt_r.cnt   = r_ff.cnt + 4'h1;
							nxt_r.shift = {r_ff.shift[6:0], 1'b0};
							nxt_r.oe    = ~r_ff.shift[6];
						end
					end
				end
				pcp_pkg::SL_ACK_RD: begin
					// A not-acknowledge ends the read burst
					if (rise && sda_i) begin
						nxt_r.st = pcp_pkg::SL_IDLE;
					end else if (fall) begin
						nxt_r.st    = pcp_pkg::SL_RD_BYTE;
						nxt_r.cnt   = 4'h0;
						nxt_r.shift = rd_data;
						nxt_r.oe    = ~rd_data[7];
					end
				end
				default: begin
					nxt_r.st = pcp_pkg::SL_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			r_ff <= '{scl_q: 1'b1, sda_q: 1'b1, st: pcp_pkg::SL_IDLE,
				default: '0};
		end else begin
			r_ff <= nxt_r;
		end
	end

	// Open-drain line: the data level is always low, only the enable moves
	assign sda_o   = 1'b0;
	assign sda_oe  = r_ff.oe;
	assign rd_addr = r_ff.ptr;
	assign wr_stb  = r_ff.wr;
	assign wr_addr = r_ff.waddr;
	assign wr_data = r_ff.wdata;

endmodule : pcp_serial_slave

// ==== pcp_props.sv ====
`timescale 1ns/100ps
module pcp_props (
	input wire logic       ref_clk,
	input wire logic       rstn,
	input wire logic       scl_i,
	input wire logic       sda_oe,
	input wire logic       clk_pin_oe,
	input wire logic       seq_up_start,
	input wire logic       seq_down_start,
	input wire logic       seq_up_done,
	input wire logic       seq_down_done,
	input wire logic       pll_enable,
	input wire logic       use_ext_ref,
	input wire logic       ref_change_event,
	input wire logic [4:0] ref_clock_rate_code,
	input wire logic [3:0] rail_uv_ok,
	input wire logic [3:0] rail_ov_ok,
	input wire logic       thermal_warning,
	input wire logic [3:0] pg_fault_flags,
	input wire logic       power_ok_valid
);
	// One clock domain, so clocking and reset are declared once
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	////////////////////////////////////////////////////////////////////////
	// A restart never ends at once, and each end is a single pulse
	a_up_not_early: assert property (seq_up_start |=> !seq_up_done)
		else $error("power-up delay ended one cycle after start");
	a_down_not_early: assert property (
		seq_down_start |=> !seq_down_done)
		else $error("power-down delay ended one cycle after start");
	a_up_pulse: assert property (seq_up_done |=> !seq_up_done)
		else $error("power-up done held longer than one cycle");
	a_down_pulse: assert property (seq_down_done |=> !seq_down_done)
		else $error("power-down done held longer than one cycle");

	////////////////////////////////////////////////////////////////////////
	// Reference clock use must be announced and needs the loop enabled
	a_event_pulse: assert property (
		ref_change_event |=> !ref_change_event)
		else $error("reference change event longer than one cycle");
	a_rise_has_event: assert property (
		$rose(use_ext_ref) |-> $past(ref_change_event))
		else $error("external reference taken without an event");
	a_ext_needs_pll: assert property (use_ext_ref |-> pll_enable)
		else $error("external reference used with the loop disabled");
	a_ext_rate_ok: assert property (
		use_ext_ref |-> ref_clock_rate_code <= 5'h17)
		else $error("external reference used with a reserved rate code");
	a_ext_pin_free: assert property (use_ext_ref |-> !clk_pin_oe)
		else $error("clock pin driven while used as clock input");

	////////////////////////////////////////////////////////////////////////
	// Healthy rails with no warning or fault always read as valid
	a_all_good_valid: assert property ((&rail_uv_ok && &rail_ov_ok
		&& !thermal_warning && pg_fault_flags == 4'h0) [*5]
		|=> power_ok_valid)
		else $error("power-ok not valid with all rails healthy");
	// The data line may only move while the serial clock is low
	a_ack_scl_low: assert property ($changed(sda_oe) |-> !scl_i)
		else $error("data line changed while serial clock high");
	a_reset_quiet: assert property ($rose(rstn)
		|-> !power_ok_valid && !sda_oe && !clk_pin_oe)
		else $error("outputs active at reset release");
endmodule : pcp_props

bind pcp_config_regs pcp_props i_props (.ref_clk, .rstn, .scl_i, .sda_oe,
	.clk_pin_oe, .seq_up_start, .seq_down_start, .seq_up_done, .seq_down_done,
	.pll_enable, .use_ext_ref, .ref_change_event, .ref_clock_rate_code,
	.rail_uv_ok, .rail_ov_ok, .thermal_warning, .pg_fault_flags,
	.power_ok_valid);

// ==== pcp_i2c_host.sv ====
`timescale 1ns/100ps
module pcp_i2c_host (
	input  wire logic ref_clk,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_pull
);
	// Bus idle: both lines released to the pull-up
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Third of a data bit; wide because the slave samples the lines on ref_clk
	task automatic hp;
		repeat (10) @(posedge ref_clk);
		#1;
	endtask : hp
	// Start or repeated start: data falls while the clock is high
	task automatic start;
		hp();
		sda_pull = 1'b0;
		hp();
		scl = 1'b1;
		hp();
		sda_pull = 1'b1;
		hp();
		scl = 1'b0;
	endtask : start
	task automatic stop;
		hp();
		sda_pull = 1'b1;
		hp();
		scl = 1'b1;
		hp();
		sda_pull = 1'b0;
		hp();
	endtask : stop
	// Drive a 1 by releasing the line, so reading and acking share one path
	task automatic byte_io(input logic [7:0] b, input logic last,
		output logic [7:0] r, output logic nak);
		logic [8:0] v;
		v = {b, last};
		for (int i = 8; i >= 0; i--) begin
			hp();
			sda_pull = ~v[i];
			hp();
			scl = 1'b1;
			hp();
			v[i] = sda;
			scl = 1'b0;
		end
		r = v[8:1];
		nak = v[0];
	endtask : byte_io

	////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		logic       nak;
		start();
		byte_io({pcp_pkg::DEV_ADDR_DEFAULT, 1'b0}, 1'b1, r, nak);
		byte_io(a, 1'b1, r, nak);
		byte_io(d, 1'b1, r, nak);
		stop();
	endtask : wr
	// Pointer write, repeated start, one byte read ended by a NACK
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		logic       nak;
		start();
		byte_io({pcp_pkg::DEV_ADDR_DEFAULT, 1'b0}, 1'b1, d, nak);
		byte_io(a, 1'b1, d, nak);
		start();
		byte_io({pcp_pkg::DEV_ADDR_DEFAULT, 1'b1}, 1'b1, d, nak);
		byte_io(8'hFF, 1'b1, d, nak);
		stop();
	endtask : rd
endmodule : pcp_i2c_host

// ==== pcp_config_regs_bench.sv ====
`timescale 1ns/100ps
module pcp_config_regs_bench;
	localparam int S = 10; // Short delay step keeps the run brief
	logic       ref_clk, rstn, scl_i, sda_pull, clk_pin_i, thermal_warning;
	logic       aux_output_two_level, aux_output_two_open_drain;
	logic       seq_up_start, seq_down_start, seq_up_done, seq_down_done;
	logic [3:0] seq_up_code, seq_down_code, rail_uv_ok, rail_ov_ok;
	logic [3:0] pg_fault_flags;
	logic       sda_o, sda_oe, clk_pin_o, clk_pin_oe, clock_pin_pulldown_on;
	logic       trigger_pin_pulldown_on, thermal_alert_threshold_sel;
	logic       dither_switching_on, pll_enable, use_ext_ref, ref_change_event;
	logic [4:0] ref_clock_rate_code;
	logic       power_ok_out_o, power_ok_out_oe, power_ok_valid;
	logic       power_ok_continuous_mode;
	wire logic  sda_i;
	int         errors, n_tests, n_ev, cyc;

	// Open-drain data line with a pull-up
	assign sda_i = ~(sda_pull | (sda_oe & ~sda_o));

	pcp_config_regs #(.STEP_FINE_CYC(S)) i_dut (.ref_clk, .rstn, .scl_i,
		.sda_i, .sda_o, .sda_oe, .clk_pin_i, .clk_pin_o, .clk_pin_oe,
		.aux_output_two_level, .aux_output_two_open_drain, .seq_up_start,
		.seq_up_code, .seq_down_start, .seq_down_code, .seq_up_done,
		.seq_down_done, .clock_pin_pulldown_on, .trigger_pin_pulldown_on,
		.thermal_alert_threshold_sel, .dither_switching_on, .pll_enable,
		.use_ext_ref, .ref_change_event, .ref_clock_rate_code, .rail_uv_ok,
		.rail_ov_ok, .thermal_warning, .pg_fault_flags, .power_ok_out_o,
		.power_ok_out_oe, .power_ok_valid, .power_ok_continuous_mode);
	pcp_i2c_host i_host (.ref_clk, .sda(sda_i), .scl(scl_i), .sda_pull);

	////////////////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// Event counter and hang guard
	always @(posedge ref_clk) begin
		n_ev += (ref_change_event === 1'b1);
		cyc++;
		if (cyc == 80000) begin
			errors++;
			results();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		i_host.rd(a, d);
		chk(d, exp);
	endtask : rchk
	function automatic logic [7:0] cfg_out;
		return {2'h0, clk_pin_o & clk_pin_oe, clk_pin_oe, clock_pin_pulldown_on,
			trigger_pin_pulldown_on, thermal_alert_threshold_sel,
			dither_switching_on};
	endfunction : cfg_out
	task automatic results;
		$display("Comparisons %0d, errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : results

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		logic [7:0] r;
		logic       nak;
		rchk(8'h13, 8'h06);
		rchk(8'h14, 8'h01);
		rchk(8'h15, 8'h73);
		rchk(8'h16, 8'h04);
		rchk(8'h20, 8'h00);
		chk({2'h0, pll_enable, ref_clock_rate_code}, 8'h01);
		// A foreign device address must not be acknowledged
		i_host.start();
		i_host.byte_io({~pcp_pkg::DEV_ADDR_DEFAULT, 1'b0}, 1'b1, r, nak);
		i_host.stop();
		chk({7'h0, nak}, 8'h01);
	endtask : t_reset

	task automatic t_cfg;
		i_host.wr(8'h13, 8'h19);
		rchk(8'h13, 8'h19);
		chk(cfg_out(), 8'h09);
		aux_output_two_level = 1'b1;
		i_host.wr(8'h13, 8'h08);
		chk(cfg_out(), 8'h38);
		aux_output_two_level = 1'b0;
		#100;
		chk(cfg_out(), 8'h18);
		// Open-drain high releases the pin instead of driving it
		{aux_output_two_level, aux_output_two_open_drain} = 2'h3;
		#100;
		chk(cfg_out(), 8'h08);
		{aux_output_two_level, aux_output_two_open_drain} = 2'h0;
	endtask : t_cfg

	task automatic t_delay(input logic up, input int exp);
		int n;
		n = 0;
		seq_up_start = up;
		seq_down_start = ~up;
		@(posedge ref_clk);
		#1;
		seq_up_start = 1'b0;
		seq_down_start = 1'b0;
		while ((up ? seq_up_done : seq_down_done) !== 1'b1 && n < 1000) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		chk({7'h0, n == exp}, 8'h01);
	endtask : t_delay

	// Full code in each range, swapped between the two sequences
	task automatic t_seq;
		seq_up_code = 4'hF;
		seq_down_code = 4'hF;
		// S cycles per half step, plus the cycle of the registered done
		i_host.wr(8'h13, 8'h46);
		t_delay(1'b1, 30 * S + 1);
		t_delay(1'b0, 15 * S + 1);
		i_host.wr(8'h13, 8'h26);
		t_delay(1'b1, 15 * S + 1);
		t_delay(1'b0, 30 * S + 1);
		seq_up_code = 4'h0;
		t_delay(1'b1, 1);
	endtask : t_seq

	task automatic toggle(input int n);
		repeat (n) begin
			@(posedge ref_clk);
			#1;
			clk_pin_i = ~clk_pin_i;
		end
	endtask : toggle

	task automatic t_pll;
		i_host.wr(8'h13, 8'h16);
		toggle(100);
		chk({6'h0, use_ext_ref, pll_enable}, 8'h00);
		chk(n_ev[7:0], 8'h00);
		i_host.wr(8'h14, 8'h45);
		toggle(50);
		chk({2'h0, use_ext_ref, ref_clock_rate_code}, 8'h25);
		chk(n_ev[7:0], 8'h01);
		repeat (260) @(posedge ref_clk);
		#1;
		chk({6'h0, use_ext_ref, clk_pin_oe}, 8'h00);
		chk(n_ev[7:0], 8'h02);
	endtask : t_pll

	// Cases hold control A, then UV-ok and OV-ok rail nibbles
	task automatic t_pok;
		logic [15:0] tc [9] = '{16'h73FF, 16'h73EF, 16'h73FE, 16'h63FC,
			16'h2CF7, 16'h8CC0, 16'h8000, 16'hC000, 16'h0F5F};
		logic [7:0]  a;
		logic        e;
		logic        lvl;
		for (int i = 0; i < 9; i++) begin
			a = tc[i][15:8];
			rail_uv_ok = tc[i][7:4];
			rail_ov_ok = tc[i][3:0];
			i_host.wr(8'h15, a);
			e = &(~a[3:0] | (rail_uv_ok
				& (rail_ov_ok | ~{a[5], a[5], a[4], a[4]})));
			lvl = e ^ a[7];
			chk({6'h0, power_ok_valid, power_ok_out_oe},
				{6'h0, e, ~a[6] | ~lvl});
			chk({7'h0, power_ok_out_o | ~power_ok_out_oe},
				{7'h0, lvl});
		end
		rail_uv_ok = 4'hF;
		rail_ov_ok = 4'hF;
		thermal_warning = 1'b1;
		i_host.wr(8'h15, 8'h73);
		chk({6'h0, power_ok_valid, power_ok_out_oe}, 8'h01);
		thermal_warning = 1'b0;
		i_host.wr(8'h16, 8'h05);
		chk({7'h0, power_ok_continuous_mode}, 8'h01);
		// Fault-flag source: a flag on a selected rail clears valid
		pg_fault_flags = 4'h1;
		i_host.wr(8'h16, 8'h02);
		chk({6'h0, power_ok_continuous_mode, power_ok_valid}, 8'h00);
		pg_fault_flags = 4'h0;
	endtask : t_pok

	////////////////////////////////////////////////////////////////////////
	// Main sequence: five reset cycles, settle, then each scenario
	initial begin
		{rstn, clk_pin_i, thermal_warning, seq_up_start, seq_down_start} = 5'h0;
		{aux_output_two_level, aux_output_two_open_drain} = 2'h0;
		{seq_up_code, seq_down_code, pg_fault_flags} = 12'h000;
		{rail_uv_ok, rail_ov_ok} = 8'hFF;
		{errors, n_tests, n_ev, cyc} = '0;
		repeat (5) @(posedge ref_clk);
		#1;
		rstn = 1'b1;
		repeat (5) @(posedge ref_clk);
		#1;
		t_reset();
		t_cfg();
		t_seq();
		t_pll();
		t_pok();
		results();
	end
endmodule : pcp_config_regs_bench
